// >>> verilog/owd_pkg.sv
// package: constants and helper functions of the orientation and wake-up detector
package owd_pkg;

    // sample and threshold widths
    localparam int SAMPLE_W = 16;
    localparam int ABS_W    = 17;

    // orientation status register layout
    localparam int STAT_DEN_BIT   = 7;
    localparam int STAT_CHG_BIT   = 6;
    localparam int STAT_ZPOS_BIT  = 5;
    localparam int STAT_ZNEG_BIT  = 4;
    localparam int STAT_YPOS_BIT  = 3;
    localparam int STAT_YNEG_BIT  = 2;
    localparam int STAT_XPOS_BIT  = 1;
    localparam int STAT_XNEG_BIT  = 0;
    localparam logic [7:0] STAT_RESET   = 8'h00;
    localparam logic [5:0] ORIENT_NONE  = 6'h00;

    // wake-up threshold field: one lsb is full scale over 2^6
    localparam int WAKEUP_THRESHOLD_FIELD_W     = 6;
    localparam int WAKEUP_THRESHOLD_FIELD_SHIFT = SAMPLE_W - 1 - WAKEUP_THRESHOLD_FIELD_W;

    // wake-up duration counter saturates at the field maximum
    localparam logic [1:0] WK_DUR_MAX = 2'h3;

    // full-scale codes and counts of one g at each
    localparam logic [1:0] FS_CODE_A = 2'h0;
    localparam logic [1:0] FS_CODE_B = 2'h1;
    localparam logic [1:0] FS_CODE_C = 2'h2;
    localparam logic [1:0] FS_CODE_D = 2'h3;
    localparam logic [15:0] ONE_G_A  = 16'h4000;
    localparam logic [15:0] ONE_G_B  = 16'h0800;
    localparam logic [15:0] ONE_G_C  = 16'h2000;
    localparam logic [15:0] ONE_G_D  = 16'h1000;

    // sine of the angle thresholds in q0.8: 80, 70, 60, 50 degrees
    localparam logic [7:0] SIN_80 = 8'hFC;
    localparam logic [7:0] SIN_70 = 8'hF1;
    localparam logic [7:0] SIN_60 = 8'hDE;
    localparam logic [7:0] SIN_50 = 8'hC4;

    // magnitude of a signed value, one bit wider so the most negative fits
    function automatic logic [ABS_W-1:0] owd_abs(input logic signed [ABS_W-1:0] v);
        owd_abs = v[ABS_W-1] ? ABS_W'(-v) : ABS_W'(v);
    endfunction

    // counts of one g for the selected full scale
    function automatic logic [15:0] owd_one_g(input logic [1:0] fs);
        case (fs)
            FS_CODE_A: owd_one_g = ONE_G_A;
            FS_CODE_B: owd_one_g = ONE_G_B;
            FS_CODE_C: owd_one_g = ONE_G_C;
            default:   owd_one_g = ONE_G_D;
        endcase
    endfunction

    // angle code to sine in q0.8
    function automatic logic [7:0] owd_sine(input logic [1:0] sel);
        case (sel)
            2'h0:    owd_sine = SIN_80;
            2'h1:    owd_sine = SIN_70;
            2'h2:    owd_sine = SIN_60;
            default: owd_sine = SIN_50;
        endcase
    endfunction

endpackage

// >>> verilog/owd_axis_cmp.sv
// module: one axis compared against the orientation threshold
`timescale 1ns/10ps
module owd_axis_cmp
    import owd_pkg::*;
(
    // axis sample and threshold
    input  wire logic signed [SAMPLE_W-1:0] value_i,
    input  wire logic        [SAMPLE_W-1:0] thr_i,
    // classification
    output logic                            above_o,
    output logic                            pos_o,
    output logic                            neg_o
);

    logic [ABS_W-1:0] mag;

    // magnitude against threshold; sign splits the face direction
    always_comb begin
        mag     = owd_abs(ABS_W'(value_i));
        above_o = mag > {1'b0, thr_i};
        pos_o   = above_o && !value_i[SAMPLE_W-1];
        neg_o   = above_o && value_i[SAMPLE_W-1];
    end

endmodule

// >>> verilog/owd_orientation_wakeup.sv
// module: orientation (6d/4d) and slope wake-up event detector
`timescale 1ns/10ps
module owd_orientation_wakeup
    import owd_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_i,
    // accelerometer samples, one strobe per output period
    input  wire logic                       sample_valid_i,
    input  wire logic signed [SAMPLE_W-1:0] accel_x_i,
    input  wire logic signed [SAMPLE_W-1:0] accel_y_i,
    input  wire logic signed [SAMPLE_W-1:0] accel_z_i,
    input  wire logic signed [SAMPLE_W-1:0] second_lowpass_filter_x_i,
    input  wire logic signed [SAMPLE_W-1:0] second_lowpass_filter_y_i,
    input  wire logic signed [SAMPLE_W-1:0] second_lowpass_filter_z_i,
    // configuration
    input  wire logic                       interrupts_enable_i,
    input  wire logic                       latch_request_select_i,
    input  wire logic [1:0]                 accel_full_scale_i,
    input  wire logic                       mode4_i,
    input  wire logic [1:0]                 orientation_angle_select_i,
    input  wire logic                       orientation_lowpass_enable_i,
    input  wire logic                       four_direction_enable_i,
    input  wire logic                       orientation_route_pin1_i,
    input  wire logic                       orientation_route_pin2_i,
    input  wire logic                       wakeup_enable_i,
    input  wire logic [WAKEUP_THRESHOLD_FIELD_W-1:0]        wakeup_threshold_field_i,
    input  wire logic [1:0]                 wakeup_duration_i,
    input  wire logic                       wakeup_route_pin1_i,
    input  wire logic                       wakeup_route_pin2_i,
    input  wire logic                       data_enable_ready_flag_i,
    // status reads
    input  wire logic                       orientation_status_rd_i,
    input  wire logic                       wakeup_status_rd_i,
    // outputs
    output logic [7:0]                      orientation_event_status_o,
    output logic                            wakeup_flag_o,
    output logic [2:0]                      wakeup_axes_o,
    output logic                            event_pin_one_o,
    output logic                            event_pin_two_o
);

    typedef struct packed {
        logic [5:0]                 cur_orient;
        logic [5:0]                 prev_cand;
        logic                       orient_int;
        logic signed [SAMPLE_W-1:0] prev_x;
        logic signed [SAMPLE_W-1:0] prev_y;
        logic signed [SAMPLE_W-1:0] prev_z;
        logic [1:0]                 wake_cnt;
        logic                       wake_int;
        logic [2:0]                 wake_axes;
        logic [7:0]                 status;
        logic                       pin1;
        logic                       pin2;
    } owd_state_s;

    owd_state_s st;
    owd_state_s next_st;

    // effective latch: unrouted events never latch
    logic orient_latch;
    logic wake_latch;
    assign orient_latch = latch_request_select_i &&
                          (orientation_route_pin1_i || orientation_route_pin2_i);
    assign wake_latch   = latch_request_select_i &&
                          (wakeup_route_pin1_i || wakeup_route_pin2_i);

    // orientation input selection; mode 4 bypasses the low-pass path
    logic                       use_lpf;
    logic signed [SAMPLE_W-1:0] ox;
    logic signed [SAMPLE_W-1:0] oy;
    logic signed [SAMPLE_W-1:0] oz;
    assign use_lpf = orientation_lowpass_enable_i && !mode4_i;
    assign ox      = use_lpf ? second_lowpass_filter_x_i : accel_x_i;
    assign oy      = use_lpf ? second_lowpass_filter_y_i : accel_y_i;
    assign oz      = use_lpf ? second_lowpass_filter_z_i : accel_z_i;

    // angle threshold in counts: one g times sine, independent of scale meaning
    logic [23:0]         ang_prod;
    logic [SAMPLE_W-1:0] ang_thr;
    assign ang_prod = owd_one_g(accel_full_scale_i) * owd_sine(orientation_angle_select_i);
    assign ang_thr  = ang_prod[23:8];

    // per-axis classification
    logic ab_x, ps_x, ng_x;
    logic ab_y, ps_y, ng_y;
    logic ab_z, ps_z, ng_z;

    owd_axis_cmp u_cmp_x (
        .value_i (ox),
        .thr_i   (ang_thr),
        .above_o (ab_x),
        .pos_o   (ps_x),
        .neg_o   (ng_x)
    );

    owd_axis_cmp u_cmp_y (
        .value_i (oy),
        .thr_i   (ang_thr),
        .above_o (ab_y),
        .pos_o   (ps_y),
        .neg_o   (ng_y)
    );

    owd_axis_cmp u_cmp_z (
        .value_i (oz),
        .thr_i   (ang_thr),
        .above_o (ab_z),
        .pos_o   (ps_z),
        .neg_o   (ng_z)
    );

    // candidate position: exactly one axis above, the rest below; four-direction mode compares x and y only and ignores z
    logic       one_above;
    logic [5:0] cand;
    always_comb begin
        if (four_direction_enable_i) begin
            one_above = ab_x ^ ab_y;
            cand      = one_above ? {2'b00, ps_y, ng_y, ps_x, ng_x} : ORIENT_NONE;
        end else begin
            one_above = (ab_x && !ab_y && !ab_z) || (!ab_x && ab_y && !ab_z) ||
                        (!ab_x && !ab_y && ab_z);
            cand      = one_above ? {ps_z, ng_z, ps_y, ng_y, ps_x, ng_x} : ORIENT_NONE;
        end
    end

    // held position across two samples that differs from the known one
    logic orient_ev;
    assign orient_ev = sample_valid_i && interrupts_enable_i &&
                       (cand != ORIENT_NONE) && (cand == st.prev_cand) &&
                       (cand != st.cur_orient) &&
                       !(orient_latch && st.orient_int);

    // wake-up threshold: field scaled so one lsb is full scale / 64
    logic [ABS_W-1:0] wk_thr;
    assign wk_thr = ABS_W'({wakeup_threshold_field_i, {WAKEUP_THRESHOLD_FIELD_SHIFT{1'b0}}});

    // slope per axis: half of current minus previous
    logic signed [ABS_W-1:0] dx, dy, dz;
    logic [2:0]              over;
    logic                    over_any;
    logic                    wake_fire;
    always_comb begin
        dx = (ABS_W'(accel_x_i) - ABS_W'(st.prev_x)) >>> 1;
        dy = (ABS_W'(accel_y_i) - ABS_W'(st.prev_y)) >>> 1;
        dz = (ABS_W'(accel_z_i) - ABS_W'(st.prev_z)) >>> 1;
        over[0]   = owd_abs(dx) > wk_thr;
        over[1]   = owd_abs(dy) > wk_thr;
        over[2]   = owd_abs(dz) > wk_thr;
        over_any  = |over;
        wake_fire = sample_valid_i && interrupts_enable_i && wakeup_enable_i &&
                    over_any && (st.wake_cnt >= wakeup_duration_i);
    end

    // next-state logic, all detection stepped by the sample strobe
    always_comb begin
        next_st = st;
        if (!interrupts_enable_i) begin
            // detection idle: drop history and pending requests
            next_st.orient_int = 1'b0;
            next_st.cur_orient = ORIENT_NONE;
            next_st.prev_cand  = ORIENT_NONE;
            next_st.wake_int   = 1'b0;
            next_st.wake_cnt   = 2'h0;
        end else begin
            // orientation
            if (orient_ev) begin
                next_st.orient_int = 1'b1;
                next_st.cur_orient = cand;
            end else if (orientation_status_rd_i && orient_latch) begin
                next_st.orient_int = 1'b0;
            end else if (sample_valid_i && !orient_latch) begin
                next_st.orient_int = 1'b0;
            end
            if (sample_valid_i) begin
                next_st.prev_cand = cand;
            end
            // wake-up
            if (wake_fire) begin
                next_st.wake_int  = 1'b1;
                next_st.wake_axes = over;
            end else if (wakeup_status_rd_i && wake_latch) begin
                next_st.wake_int = 1'b0;
            end else if (sample_valid_i && !wake_latch) begin
                next_st.wake_int = 1'b0;
            end
            if (sample_valid_i && wakeup_enable_i) begin
                if (!over_any) begin
                    next_st.wake_cnt = 2'h0;
                end else if (st.wake_cnt != WK_DUR_MAX) begin
                    next_st.wake_cnt = st.wake_cnt + 2'h1;
                end
            end
        end
        // history: zero while wake-up is off, so the first slope sees (0,0,0)
        if (!wakeup_enable_i || !interrupts_enable_i) begin
            next_st.prev_x   = '0;
            next_st.prev_y   = '0;
            next_st.prev_z   = '0;
            next_st.wake_cnt = 2'h0;
        end else if (sample_valid_i) begin
            next_st.prev_x = accel_x_i;
            next_st.prev_y = accel_y_i;
            next_st.prev_z = accel_z_i;
        end
        // readable status and pins come from the same registered state
        next_st.status = {data_enable_ready_flag_i, next_st.orient_int, next_st.cur_orient};
        next_st.pin1   = (next_st.orient_int && orientation_route_pin1_i) ||
                         (next_st.wake_int && wakeup_route_pin1_i);
        next_st.pin2   = (next_st.orient_int && orientation_route_pin2_i) ||
                         (next_st.wake_int && wakeup_route_pin2_i);
    end

    // state register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st        <= '0;
            st.status <= STAT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign orientation_event_status_o = st.status;
    assign wakeup_flag_o              = st.wake_int;
    assign wakeup_axes_o              = st.wake_axes;
    assign event_pin_one_o            = st.pin1;
    assign event_pin_two_o            = st.pin2;

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_pin_or_route: assert property (
        event_pin_one_o == ((st.orient_int && $past(orientation_route_pin1_i)) ||
                            (st.wake_int && $past(wakeup_route_pin1_i))))
        else $error("pin one is not the OR of routed sources");

    a_pin_two_or: assert property (
        event_pin_two_o == ((st.orient_int && $past(orientation_route_pin2_i)) ||
                            (st.wake_int && $past(wakeup_route_pin2_i))))
        else $error("pin two is not the OR of routed sources");

    a_change_onehot: assert property (
        orientation_event_status_o[STAT_CHG_BIT] |->
        $onehot(orientation_event_status_o[5:0]))
        else $error("change flag without exactly one axis flag");

    a_fourd_no_z: assert property (
        ($rose(st.orient_int) && $past(four_direction_enable_i)) |->
        (st.cur_orient[5:4] == 2'b00))
        else $error("z flag set in four-direction mode");

    a_enable_gate: assert property (
        !interrupts_enable_i |=> (!st.orient_int && !st.wake_int))
        else $error("event active with interrupts disabled");

    // a fresh change on the same strobe legally restarts the pulse
    a_unlatched_pulse: assert property (
        (st.orient_int && sample_valid_i && !orient_latch && interrupts_enable_i &&
         !orient_ev) |=> !st.orient_int)
        else $error("unlatched orientation held past one period");

    a_unrouted_nolatch: assert property (
        (st.orient_int && latch_request_select_i && !orientation_route_pin1_i &&
         !orientation_route_pin2_i && sample_valid_i && interrupts_enable_i &&
         !orient_ev) |=> !st.orient_int)
        else $error("unrouted orientation request was latched");

    a_latch_hold: assert property (
        (st.orient_int && orient_latch && interrupts_enable_i && !orientation_status_rd_i) |=>
        st.orient_int)
        else $error("latched orientation dropped without read");

    a_read_clears: assert property (
        (st.orient_int && orient_latch && orientation_status_rd_i &&
         interrupts_enable_i) |=> !st.orient_int)
        else $error("status read did not clear latched orientation");

    a_pair_needed: assert property (
        (sample_valid_i && cand != st.prev_cand) |=> !$rose(st.orient_int))
        else $error("orientation event from a single sample");

    a_no_reassert: assert property (
        (sample_valid_i && interrupts_enable_i && !orient_latch &&
         cand == st.cur_orient) |=> !st.orient_int)
        else $error("orientation re-asserted while held");

    // wake-up slope path
    a_wake_dur0: assert property (
        (sample_valid_i && interrupts_enable_i && wakeup_enable_i &&
         wakeup_duration_i == 2'h0 && over_any) |=> (st.wake_int && wakeup_flag_o))
        else $error("wake-up missed with zero duration");

    a_wake_pulse: assert property (
        (st.wake_int && sample_valid_i && !wake_latch && interrupts_enable_i &&
         !wake_fire) |=> !st.wake_int)
        else $error("unlatched wake-up held past one period");

    // independent of the over vector, so a broken compare shows up here
    a_wake_quiet: assert property (
        (sample_valid_i && interrupts_enable_i && !wake_latch && owd_abs(dx) <= wk_thr &&
         owd_abs(dy) <= wk_thr && owd_abs(dz) <= wk_thr) |=> !st.wake_int)
        else $error("wake-up raised with every slope inside threshold");

    a_history_zero: assert property (
        !wakeup_enable_i |=> (st.prev_x == '0 && st.prev_y == '0 && st.prev_z == '0))
        else $error("slope history not cleared while wake-up is off");

    // coverage of the main scenarios
    c_orient_event: cover property ($rose(st.orient_int));
    c_wake_event:   cover property ($rose(st.wake_int) && wakeup_duration_i == 2'h0);
    c_latched_read: cover property (st.orient_int && orient_latch ##1 orientation_status_rd_i);
    c_fourd_event:  cover property ($rose(st.orient_int) && $past(four_direction_enable_i));
    c_unrouted:     cover property (latch_request_select_i && !orient_latch &&
                                    $fell(st.orient_int));

endmodule

// >>> tb/owd_host_model.sv
// host processor model: status register reads and wake-up flag event counting
`timescale 1ns/10ps
module owd_host_model
    import owd_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // bench request and device outputs
    input  wire logic       read_req_i,
    input  wire logic [7:0] status_i,
    input  wire logic       wake_flag_i,
    // read strobe and results
    output logic            status_rd_o,
    output logic            read_done_o,
    output logic [7:0]      read_value_o,
    output logic [3:0]      wake_events_o
);
    logic wake_seen;
    logic wake_prev;

    // one read pulse per request, value taken at the edge that samples it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_rd_o   <= 1'b0;
            read_done_o   <= 1'b0;
            read_value_o  <= 8'h00;
            wake_events_o <= 4'h0;
            wake_seen     <= 1'b0;
            wake_prev     <= 1'b0;
        end else begin
            status_rd_o <= read_req_i & ~status_rd_o;
            read_done_o <= status_rd_o;
            if (status_rd_o) begin
                read_value_o <= status_i;
            end
            wake_prev <= wake_flag_i;
            // first wake-up after reset may be spurious, so it is not counted
            if (wake_flag_i & ~wake_prev) begin
                wake_seen <= 1'b1;
                if (wake_seen) begin
                    wake_events_o <= wake_events_o + 4'h1;
                end
            end
        end
    end
endmodule

// >>> tb/owd_orientation_wakeup_tb.sv
// testbench: orientation and wake-up detector scenarios
`timescale 1ns/10ps
module owd_orientation_wakeup_tb
    import owd_pkg::*;
;
    localparam logic [15:0] G_TAB [4] = '{ONE_G_A, ONE_G_B, ONE_G_C, ONE_G_D};
    localparam logic [7:0]  S_TAB [4] = '{SIN_80, SIN_70, SIN_60, SIN_50};
    logic                       core_clk_i, rst, sv, hreq, p1, p2, wflag, hrd, hdone;
    logic signed [SAMPLE_W-1:0] ax, ay, az, lx, ly, lz;
    logic                       en, lat, m4, lp, d4, r1, r2, wen, wr1, wr2, den;
    logic [1:0]                 fs, ang, wdur;
    logic [WAKEUP_THRESHOLD_FIELD_W-1:0]        wth;
    logic [7:0]                 stat, hval;
    logic [2:0]                 waxes;
    logic [3:0]                 hcnt;
    int                         n_fail = 0;
    int                         samples_checked = 0;

    owd_orientation_wakeup dut (
        .core_clk_i(core_clk_i), .rst_i(rst), .sample_valid_i(sv),
        .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az),
        .second_lowpass_filter_x_i(lx), .second_lowpass_filter_y_i(ly), .second_lowpass_filter_z_i(lz),
        .interrupts_enable_i(en), .latch_request_select_i(lat),
        .accel_full_scale_i(fs), .mode4_i(m4), .orientation_angle_select_i(ang),
        .orientation_lowpass_enable_i(lp), .four_direction_enable_i(d4),
        .orientation_route_pin1_i(r1), .orientation_route_pin2_i(r2),
        .wakeup_enable_i(wen), .wakeup_threshold_field_i(wth),
        .wakeup_duration_i(wdur), .wakeup_route_pin1_i(wr1), .wakeup_route_pin2_i(wr2),
        .data_enable_ready_flag_i(den), .orientation_status_rd_i(hrd),
        .wakeup_status_rd_i(1'b0), .orientation_event_status_o(stat),
        .wakeup_flag_o(wflag), .wakeup_axes_o(waxes),
        .event_pin_one_o(p1), .event_pin_two_o(p2)
    );

    owd_host_model host (
        .core_clk_i(core_clk_i), .rst_i(rst), .read_req_i(hreq), .status_i(stat),
        .wake_flag_i(wflag), .status_rd_o(hrd), .read_done_o(hdone),
        .read_value_o(hval), .wake_events_o(hcnt)
    );

    // 125 MHz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // defaults: interrupts on, orientation routed to pin one, all else off
    task automatic restart();
        rst = 1'b1;
        {en, lat, m4, lp, d4, r1, r2, wen, wr1, wr2, den, hreq, sv} = 13'h1080;
        {fs, ang, wdur, wth} = 12'h000;
        {ax, ay, az, lx, ly, lz} = '0;
        repeat (2) @(posedge core_clk_i);
        #1 rst = 1'b0;
    endtask

    // one idle edge first, so a strobe is never raised where it was lowered
    task automatic strobe(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge core_clk_i) #1 sv = 1'b1;
        ax = x;
        ay = y;
        az = z;
        @(posedge core_clk_i) #1 sv = 1'b0;
    endtask

    task automatic host_read();
        int n;
        hreq = 1'b1;
        for (n = 0; n < 8 && hdone !== 1'b1; n++) @(posedge core_clk_i) #1;
        hreq = 1'b0;
        if (n == 8) begin
            chk("host read done", 8'h01, 8'h00);
            stop_test();
        end
    endtask

    task automatic t_six();
        logic [7:0]  prev;
        logic [15:0] v, x, y, z;
        int          b;
        prev = 8'h00;
        restart();
        for (int k = 0; k < 6; k++) begin
            b = (k / 2) * 2 + ((k % 2) ? 0 : 1);
            v = (k % 2) ? -ONE_G_A : ONE_G_A;
            x = (k < 2) ? v : 16'h0000;
            y = (k / 2 == 1) ? v : 16'h0000;
            z = (k > 3) ? v : 16'h0000;
            r1 = (k % 2 == 0);
            r2 = ~r1;
            strobe(x, y, z);
            chk("status first sample", prev, stat);
            strobe(x, y, z);
            chk("status change", 8'h40 | (8'h01 << b), stat);
            chk("pins on change", {6'h00, r2, r1}, {6'h00, p2, p1});
            strobe(x, y, z);
            prev = 8'h01 << b;
            chk("status held", prev, stat);
            chk("pins held", 8'h00, {6'h00, p2, p1});
        end
        $display("test six orientations done");
    endtask

    task automatic t_pair();
        restart();
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, ONE_G_A, 16'h0000);
        chk("single sample", 8'h20, stat);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("same orientation", 8'h20, stat);
        $display("test consecutive pair done");
    endtask

    // each scale and angle code, just below then just above its threshold
    task automatic t_angle();
        logic [15:0] thr, lo, hi;
        logic [7:0]  prev;
        prev = 8'h00;
        restart();
        for (int i = 0; i < 4; i++) begin
            fs = 2'(i);
            ang = 2'(i);
            thr = 16'((32'(G_TAB[i]) * S_TAB[i]) >> 8);
            lo = (i % 2) ? -(thr - 16'h0008) : thr - 16'h0008;
            hi = (i % 2) ? -(thr + 16'h0008) : thr + 16'h0008;
            strobe(16'h0000, 16'h0000, lo);
            strobe(16'h0000, 16'h0000, lo);
            chk("below angle", prev, stat);
            strobe(16'h0000, 16'h0000, hi);
            strobe(16'h0000, 16'h0000, hi);
            prev = (i % 2) ? 8'h10 : 8'h20;
            chk("above angle", 8'h40 | prev, stat);
        end
        $display("test angle codes done");
    endtask

    task automatic t_modes();
        restart();
        en = 1'b0;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("disabled", 8'h00, {p1, stat[6:0]});
        en = 1'b1;
        den = 1'b1;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("enabled with den", 8'hE0, stat);
        restart();
        d4 = 1'b1;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("four direction z", 8'h00, stat);
        strobe(ONE_G_A, 16'h0000, 16'h0000);
        strobe(ONE_G_A, 16'h0000, 16'h0000);
        chk("four direction x", 8'h42, stat);
        restart();
        lp = 1'b1;
        lx = ONE_G_A;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("lowpass source", 8'h42, stat);
        m4 = 1'b1;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("mode four source", 8'h60, stat);
        $display("test modes done");
    endtask

    task automatic t_latch();
        restart();
        lat = 1'b1;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(ONE_G_A, 16'h0000, 16'h0000);
        strobe(ONE_G_A, 16'h0000, 16'h0000);
        chk("latched blocked", 8'h60, stat);
        chk("latched pin", 8'h01, {7'h00, p1});
        host_read();
        chk("read value", 8'h60, hval);
        chk("after read", 8'h20, {p1, stat[6:0]});
        strobe(ONE_G_A, 16'h0000, 16'h0000);
        strobe(ONE_G_A, 16'h0000, 16'h0000);
        chk("re-armed", 8'h42, stat);
        r1 = 1'b0;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("latch unrouted", 8'h20, stat);
        $display("test latch done");
    endtask

    // slope threshold is field times 2^9 counts; first sample sees zero history
    task automatic t_wake();
        logic [15:0] tc, x;
        restart();
        wen = 1'b1;
        wth = 6'h02;
        wr1 = 1'b1;
        wr2 = 1'b1;
        tc = 16'h0002 << WAKEUP_THRESHOLD_FIELD_SHIFT;
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("first wake", 8'h0C, {4'h0, wflag, waxes});
        chk("wake pins", 8'h03, {6'h00, p2, p1});
        strobe(16'h0000, 16'h0000, ONE_G_A);
        chk("wake drop", 8'h00, {7'h00, wflag});
        chk("pins with change", 8'h01, {6'h00, p2, p1});
        x = -(2 * tc + 16'h0004);
        strobe(x, 16'h0000, ONE_G_A);
        chk("negative slope", 8'h09, {4'h0, wflag, waxes});
        strobe(x - (2 * tc - 16'h0002), 16'h0000, ONE_G_A);
        chk("below threshold", 8'h00, {p2, wflag});
        chk("host wake count", 8'h01, {4'h0, hcnt});
        // duration one: the first over sample only arms the counter
        wdur = 2'h1;
        strobe(16'h2000, 16'h0000, ONE_G_A);
        chk("duration one first over", 8'h00, {7'h00, wflag});
        strobe(16'hE000, 16'h0000, ONE_G_A);
        chk("duration one second over", 8'h09, {4'h0, wflag, waxes});
        $display("test wake done");
    endtask

    initial begin
        t_six();
        t_pair();
        t_angle();
        t_modes();
        t_latch();
        t_wake();
        stop_test();
    end
endmodule
